/* include/abu_pkg.sv */
// Package with register map, field positions and encodings of the breakpoint unit.
package abu_pkg;
    // Register byte addresses on the APB slave.
    localparam logic [7:0] ADDR_CONTROL_STATUS = 8'h00;
    localparam logic [7:0] ADDR_ADDRESS_HIGH = 8'h04;
    localparam logic [7:0] ADDR_ADDRESS_LOW = 8'h08;
    localparam logic [7:0] ADDR_WAIT_STATUS = 8'h0c;
    localparam logic [7:0] ADDR_FLAG_CONTROL = 8'h10;
    // Field positions.
    localparam int BIT_BREAK_ENABLE = 7;
    localparam int BIT_BREAK_ACTIVE = 6;
    localparam int BIT_WAIT_EXIT = 1;
    localparam int BIT_CLEAR_ENABLE = 7;
    // Values after reset.
    localparam logic [7:0] RST_BYTE = 8'h00;
    // Break vectors, normal and monitor mode.
    localparam logic [15:0] VEC_NORMAL = 16'hfffc;
    localparam logic [15:0] VEC_MONITOR = 16'hfefc;
    // Software interrupt opcode forced into the instruction register.
    localparam logic [7:0] SWI_OPCODE = 8'h83;
    // Break state machine.
    typedef enum logic [1:0] {
        ABU_IDLE = 2'b00,
        ABU_PEND = 2'b01,
        ABU_BREAK = 2'b10
    } abu_state_e;
endpackage

/* src/abu_match.sv */
`timescale 1ns/1ps
// Program-address comparator against the stored break address.
module abu_match #(
    parameter int AW = 16
) (
    input wire logic [AW-1:0] addr,
    input wire logic [AW-1:0] brk_addr,
    input wire logic valid,
    output logic hit
);
    // Elaboration-time guard; a zero-width compare would hit on every fetch.
    if (AW < 1) begin : g_bad_width
        $error("abu_match: address width must be positive");
    end
    // Only a CPU program fetch cycle counts; an idle bus never hits.
    assign hit = valid && (addr == brk_addr);
endmodule // abu_match

/* src/abu_reg8.sv */
`timescale 1ns/1ps
// Byte register with synchronous reset and write strobe.
module abu_reg8 (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic we,
    input wire logic [7:0] din,
    output logic [7:0] q
);
    // Holds a byte; cleared on reset.
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            q <= abu_pkg::RST_BYTE;
        end else if (we) begin
            q <= din;
        end
    end
endmodule // abu_reg8

/* src/abu_top.sv */
`timescale 1ns/1ps
// Address breakpoint unit: APB registers, address match and break state.

// Notes on behaviour
// R1: Enabled address match raises breakpoint request.
// R2: Integration unit then forces software interrupt opcode.
// R3: Vector FFFC normally, FEFC in monitor mode.
// R4: Writing one to active bit forces break.
// R5: Opcode-address match stops that instruction executing.
// R6: Operand-address match lets instruction complete first.
// R7: Return-from-interrupt ends the break state.
// R8: Enable bit 7 gates matches; reset clears.
// R9: Match sets active bit; software zero clears.
// R10: Two address bytes, both zero after reset.
// R11: Cleared active bit, same address: no rebreak.
// R12: Flags clearable in break only when enabled.
// R13: Wait-exit flag shows break ended wait mode.
// R14: Timer counter held during break.
// R15: Watchdog off in break with test voltage.
// R16: Comparator active in wait and stop modes.
// R17: Clear enable and wait flag reset zero.
module abu_top (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [15:0] cpu_addr,
    input wire logic cpu_addr_valid,
    input wire logic cpu_opcode_fetch,
    input wire logic cpu_instr_boundary,
    input wire logic cpu_rti_done,
    input wire logic cpu_in_wait,
    input wire logic monitor_mode,
    input wire logic high_test_voltage_pin,
    output logic breakpoint_request,
    output logic [15:0] break_vector,
    output logic break_state,
    output logic status_clear_allowed,
    output logic timer_hold,
    output logic watchdog_disable
);
    logic wr_en;
    logic rd_en;
    logic hit;
    logic break_entry;
    logic ctrl_break_enable_r;
    logic ctrl_break_active_r;
    logic wait_exit_r;
    logic clear_enable_r;
    logic armed_r;
    logic sw_pend_r;
    logic tv_meta_r;
    logic tv_sync_r;
    logic [7:0] addr_high;
    logic [7:0] addr_low;
    logic addr_write;
    logic active_wr;
    abu_pkg::abu_state_e state_r;
    abu_pkg::abu_state_e state_nxt;

    // Writes land at the access edge. The setup cycle stages read data and
    // the ready answer, so every transfer completes with no wait state.
    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && !penable;
    assign addr_write = wr_en && (paddr == abu_pkg::ADDR_ADDRESS_HIGH
                                  || paddr == abu_pkg::ADDR_ADDRESS_LOW);
    assign active_wr = wr_en && paddr == abu_pkg::ADDR_CONTROL_STATUS;

    // A break is taken from an address only while enabled and armed; the
    // same term feeds the active bit, the disarm and the sequencer, so they
    // can never disagree about which fetch caused the break.
    assign break_entry = hit && ctrl_break_enable_r && armed_r; // [R1] [R8]

    // Elaboration-time guard: the register fields must sit inside the byte
    // that the bus carries, or a write would land in bits nobody decodes.
    if (abu_pkg::BIT_BREAK_ENABLE > 7 || abu_pkg::BIT_BREAK_ACTIVE > 7
        || abu_pkg::BIT_WAIT_EXIT > 7
        || abu_pkg::BIT_CLEAR_ENABLE > 7) begin : g_bad_field
        $error("abu_top: register field outside the data byte");
    end

    // Address bytes. [R10]
    abu_reg8 u_high (
        .mclk(mclk),
        .nrst(nrst),
        .we(wr_en && paddr == abu_pkg::ADDR_ADDRESS_HIGH),
        .din(pwdata[7:0]),
        .q(addr_high)
    );
    abu_reg8 u_low (
        .mclk(mclk),
        .nrst(nrst),
        .we(wr_en && paddr == abu_pkg::ADDR_ADDRESS_LOW),
        .din(pwdata[7:0]),
        .q(addr_low)
    );

    // The comparator runs in wait and stop too; a frozen bus never hits. [R16]
    abu_match #(.AW(16)) u_match (
        .addr(cpu_addr),
        .brk_addr({addr_high, addr_low}),
        .valid(cpu_addr_valid),
        .hit(hit)
    );

    // Test voltage detector comes from a pin, so it is synchronised. Only
    // the second stage is read; the first may still be settling.
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            tv_meta_r <= 1'b0;
            tv_sync_r <= 1'b0;
        end else begin
            tv_meta_r <= high_test_voltage_pin;
            tv_sync_r <= tv_meta_r;
        end
    end

    // Break enable bit, cleared by writing zero or by reset. [R8]
    // It gates only address matches; a software break ignores it.
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            ctrl_break_enable_r <= 1'b0;
        end else if (active_wr) begin
            ctrl_break_enable_r <= pwdata[abu_pkg::BIT_BREAK_ENABLE];
        end
    end

    // One match per arming: once the active bit has been cleared without
    // rewriting the address, the same address stays silent. Rewriting
    // either address byte re-arms the comparator. [R11]
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            armed_r <= 1'b1;
        end else if (addr_write) begin
            armed_r <= 1'b1;
        end else if (break_entry) begin
            armed_r <= 1'b0;
        end
    end

    // Active bit: a hardware match wins over a simultaneous zero write. [R9]
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            ctrl_break_active_r <= 1'b0;
        end else if (break_entry) begin
            ctrl_break_active_r <= 1'b1; // [R1] [R9]
        end else if (active_wr) begin
            ctrl_break_active_r <= pwdata[abu_pkg::BIT_BREAK_ACTIVE];
        end
    end

    // Software break waits for the next instruction boundary, so the
    // instruction in flight always completes first. [R4]
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            sw_pend_r <= 1'b0;
        end else if (active_wr && pwdata[abu_pkg::BIT_BREAK_ACTIVE]) begin
            sw_pend_r <= 1'b1;
        end else if (state_r == abu_pkg::ABU_BREAK) begin
            sw_pend_r <= 1'b0;
        end
    end

    // Break sequencing. An opcode hit breaks at once, so the fetched opcode
    // is replaced; an operand hit waits for the instruction boundary.
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            abu_pkg::ABU_IDLE: begin
                if (break_entry) begin
                    if (cpu_opcode_fetch) begin
                        state_nxt = abu_pkg::ABU_BREAK; // [R5]
                    end else begin
                        state_nxt = abu_pkg::ABU_PEND; // [R6]
                    end
                end else if (sw_pend_r && cpu_instr_boundary) begin
                    state_nxt = abu_pkg::ABU_BREAK; // [R4]
                end
            end
            abu_pkg::ABU_PEND: begin
                if (cpu_instr_boundary) begin
                    state_nxt = abu_pkg::ABU_BREAK; // [R6]
                end
            end
            abu_pkg::ABU_BREAK: begin
                if (cpu_rti_done) begin
                    state_nxt = abu_pkg::ABU_IDLE; // [R7]
                end
            end
            default: state_nxt = abu_pkg::ABU_IDLE;
        endcase
    end

    // State register; reset always returns to idle with no break pending.
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            state_r <= abu_pkg::ABU_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Wait-exit flag: set when a break leaves wait mode; zero write clears,
    // but a new event in the same cycle wins. [R13] [R17]
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            wait_exit_r <= 1'b0;
        end else if (cpu_in_wait && state_nxt == abu_pkg::ABU_BREAK
                     && state_r != abu_pkg::ABU_BREAK) begin
            wait_exit_r <= 1'b1; // [R13]
        end else if (wr_en && paddr == abu_pkg::ADDR_WAIT_STATUS
                     && !pwdata[abu_pkg::BIT_WAIT_EXIT]) begin
            wait_exit_r <= 1'b0;
        end
    end

    // Clear-flag enable, protected by default. [R12] [R17]
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            clear_enable_r <= 1'b0;
        end else if (wr_en && paddr == abu_pkg::ADDR_FLAG_CONTROL) begin
            clear_enable_r <= pwdata[abu_pkg::BIT_CLEAR_ENABLE];
        end
    end

    // Break level outputs, all registered from the next state so they rise
    // together. The request is a level held for the whole break so the
    // integration unit can sample it at any edge; the timer freezes with it.
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            breakpoint_request <= 1'b0;
            break_state <= 1'b0;
            timer_hold <= 1'b0;
        end else begin
            breakpoint_request <= state_nxt == abu_pkg::ABU_BREAK; // [R1]
            break_state <= state_nxt == abu_pkg::ABU_BREAK;
            timer_hold <= state_nxt == abu_pkg::ABU_BREAK; // [R14]
        end
    end

    // Vector select follows the mode input one cycle late; the integration
    // unit only reads it after the request has stood for a cycle.
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            break_vector <= abu_pkg::VEC_NORMAL;
        end else begin
            break_vector <= monitor_mode ? abu_pkg::VEC_MONITOR
                                         : abu_pkg::VEC_NORMAL; // [R3]
        end
    end

    // Flag protection: outside a break clearing is always allowed; inside
    // it only once software has set the clear enable.
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            status_clear_allowed <= 1'b1;
        end else begin
            status_clear_allowed <= state_nxt != abu_pkg::ABU_BREAK
                                    || clear_enable_r; // [R12]
        end
    end

    // Watchdog suppression uses the synchronised test voltage level, so a
    // glitch on the pin cannot drop the watchdog for a partial cycle.
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            watchdog_disable <= 1'b0;
        end else begin
            watchdog_disable <= state_nxt == abu_pkg::ABU_BREAK
                                && tv_sync_r; // [R15]
        end
    end

    // APB read data; unmapped addresses read zero with an error. Writes to
    // an unmapped address are dropped, so no register is ever aliased.
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
            pready <= 1'b0;
        end else begin
            pready <= rd_en;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
            if (rd_en) begin
                case (paddr)
                    abu_pkg::ADDR_CONTROL_STATUS:
                        prdata[7:0] <= {ctrl_break_enable_r,
                                        ctrl_break_active_r, 6'h00};
                    abu_pkg::ADDR_ADDRESS_HIGH: prdata[7:0] <= addr_high;
                    abu_pkg::ADDR_ADDRESS_LOW: prdata[7:0] <= addr_low;
                    abu_pkg::ADDR_WAIT_STATUS:
                        prdata[abu_pkg::BIT_WAIT_EXIT] <= wait_exit_r;
                    abu_pkg::ADDR_FLAG_CONTROL:
                        prdata[abu_pkg::BIT_CLEAR_ENABLE] <= clear_enable_r;
                    default: pslverr <= 1'b1;
                endcase
            end
        end
    end
endmodule // abu_top

/* testbench/abu_assertions.sv */
// Port-level checks for the address breakpoint unit.
`timescale 1ns/1ps
module abu_assertions (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic cpu_rti_done,
    input wire logic monitor_mode,
    input wire logic breakpoint_request,
    input wire logic [15:0] break_vector,
    input wire logic break_state,
    input wire logic timer_hold,
    input wire logic watchdog_disable
);
    // One clock domain, so clocking and reset are given once.
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    a_timer_hold_break: assert property (
        timer_hold == break_state) else $error("timer hold not break");
    a_request_is_state: assert property (
        breakpoint_request == break_state) else $error("request not state");
    a_vector_by_mode: assert property (
        ##1 break_vector == ($past(monitor_mode) ? abu_pkg::VEC_MONITOR
        : abu_pkg::VEC_NORMAL)) else $error("break vector wrong");
    a_return_ends_break: assert property (
        cpu_rti_done && break_state |-> ##[1:2] !break_state)
        else $error("break outlived return");
    a_wdog_only_break: assert property (
        watchdog_disable |-> break_state || $past(break_state))
        else $error("watchdog off outside break");
    a_pready_first: assert property (
        psel && !penable |=> pready) else $error("pready late");
    a_pready_single: assert property (
        pready |=> !pready) else $error("pready stands too long");
    a_upper_zero: assert property (
        pready |-> prdata[31:8] == 24'h0) else $error("upper read bits set");
    a_error_with_ready: assert property (
        pslverr |-> pready) else $error("error answer without ready");
endmodule // abu_assertions

/* testbench/abu_cpu_model.sv */
// Behavioural CPU and integration unit facing the breakpoint unit.
`timescale 1ns/1ps
module abu_cpu_model (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic brk,
    input wire logic [7:0] rti_delay,
    output logic [15:0] addr,
    output logic valid,
    output logic opc,
    output logic bnd,
    output logic return_from_interrupt_opcode
);
    logic [15:0] pc_r;
    logic [7:0] cnt_r;
    // Program loops over sixteen bytes, so any address comes round again.
    // In break the fetch stops while the forced routine runs, then returns.
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            pc_r <= 16'h1000;
            valid <= 1'b0;
            cnt_r <= 8'h00;
            return_from_interrupt_opcode <= 1'b0;
        end else if (brk) begin
            valid <= 1'b0;
            cnt_r <= cnt_r + 8'h01;
            return_from_interrupt_opcode <= (cnt_r == rti_delay);
        end else begin
            pc_r <= {pc_r[15:4], pc_r[3:0] + 4'h1};
            valid <= 1'b1;
            cnt_r <= 8'h00;
            return_from_interrupt_opcode <= 1'b0;
        end
    end
    // A released bus shows the inverse, so a stale match cannot pass.
    assign addr = valid ? pc_r : ~pc_r;
    assign opc = valid & ~pc_r[0];
    assign bnd = opc;
endmodule // abu_cpu_model

/* testbench/abu_top_tb.sv */
// Self-checking bench for the address breakpoint unit.
`timescale 1ns/1ps
module abu_top_tb;
    logic mclk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, cpu_in_wait = 1'b0, monitor_mode = 1'b0;
    logic high_test_voltage_pin = 1'b0;
    logic [7:0] paddr = 8'h00, rti_dly = 8'h3c, lo;
    logic [31:0] pwdata = 32'h0, prdata, lfsr = 32'hdae93445;
    logic pready, pslverr, breakpoint_request, break_state, timer_hold;
    logic status_clear_allowed, watchdog_disable, cpu_addr_valid;
    logic cpu_opcode_fetch, cpu_instr_boundary, cpu_rti_done;
    logic [15:0] break_vector, cpu_addr;
    logic [7:0] exp_q[$];
    logic [7:0] exp_b;
    int n_fail = 0, cmp_count = 0;

    abu_top uut (
        .mclk(mclk),
        .nrst(nrst),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .cpu_addr(cpu_addr),
        .cpu_addr_valid(cpu_addr_valid),
        .cpu_opcode_fetch(cpu_opcode_fetch),
        .cpu_instr_boundary(cpu_instr_boundary),
        .cpu_rti_done(cpu_rti_done),
        .cpu_in_wait(cpu_in_wait),
        .monitor_mode(monitor_mode),
        .high_test_voltage_pin(high_test_voltage_pin),
        .breakpoint_request(breakpoint_request),
        .break_vector(break_vector),
        .break_state(break_state),
        .status_clear_allowed(status_clear_allowed),
        .timer_hold(timer_hold),
        .watchdog_disable(watchdog_disable)
    );
    abu_cpu_model cpu (.mclk(mclk), .nrst(nrst), .brk(break_state),
        .rti_delay(rti_dly), .addr(cpu_addr), .valid(cpu_addr_valid),
        .opc(cpu_opcode_fetch), .bnd(cpu_instr_boundary), .return_from_interrupt_opcode(cpu_rti_done));

    // Free-running bus clock of 100 ns.
    initial begin
        forever #50 mclk = ~mclk;
    end

    task automatic final_report();
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string s, input logic [15:0] e, g);
        cmp_count++;
        if (g !== e) begin
            n_fail++;
            $display("Error %s expected %h seen %h", s, e, g);
        end
    endtask

    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction

    // One APB transfer; a read notes its expected byte for the monitor.
    task automatic apb(input logic w, input logic [7:0] a, d);
        int n;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        if (!w) exp_q.push_back(d);
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            n_fail++;
            final_report();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Bounded wait for the break request to reach a level.
    task automatic wait_bk(input logic e);
        int n;
        for (n = 0; n < 300 && breakpoint_request !== e; n++) @(posedge mclk);
        if (breakpoint_request !== e) begin
            n_fail++;
            final_report();
        end
    endtask

    // Read data and the error answer are taken where the access completes.
    always @(posedge mclk) begin
        if (psel && penable && pready === 1'b1) begin
            chk("slave error", {15'h0, paddr > abu_pkg::ADDR_FLAG_CONTROL},
                {15'h0, pslverr});
            if (!pwrite) begin
                exp_b = exp_q.pop_front();
                chk("read data", {8'h0, exp_b}, prdata[15:0]);
            end
        end
    end

    initial begin
        repeat (4) @(posedge mclk);
        nrst <= 1'b1;
        for (int i = 0; i <= 20; i += 4) apb(1'b0, i[7:0], 8'h00);
        $display("reset values done");
        lfsr = lfsr_next(lfsr);
        lo = {4'h0, lfsr[3:1], 1'b0};
        high_test_voltage_pin <= 1'b1;
        apb(1'b1, 8'h04, 8'h10);
        apb(1'b1, 8'h08, lo);
        apb(1'b0, 8'h08, lo);
        apb(1'b1, 8'h00, 8'h80);
        wait_bk(1'b1);
        repeat (3) @(posedge mclk);
        chk("timer hold", 16'h1, {15'h0, timer_hold});
        chk("watchdog off", 16'h1, {15'h0, watchdog_disable});
        chk("vector", 16'hfffc, break_vector);
        chk("clear ok", 16'h0, {15'h0, status_clear_allowed});
        apb(1'b1, 8'h10, 8'h80);
        apb(1'b0, 8'h10, 8'h80);
        chk("clear ok", 16'h1, {15'h0, status_clear_allowed});
        apb(1'b0, 8'h00, 8'hc0);
        apb(1'b1, 8'h00, 8'h80);
        apb(1'b0, 8'h00, 8'h80);
        wait_bk(1'b0);
        repeat (40) @(posedge mclk);
        chk("no rebreak", 16'h0, {15'h0, breakpoint_request});
        $display("address break done");
        monitor_mode <= 1'b1;
        high_test_voltage_pin <= 1'b0;
        rti_dly <= 8'h03;
        apb(1'b1, 8'h08, lo ^ 8'h02);
        wait_bk(1'b1);
        chk("vector", 16'hfefc, break_vector);
        chk("watchdog on", 16'h0, {15'h0, watchdog_disable});
        wait_bk(1'b0);
        apb(1'b1, 8'h00, 8'h00);
        cpu_in_wait <= 1'b1;
        apb(1'b1, 8'h00, 8'h40);
        wait_bk(1'b1);
        cpu_in_wait <= 1'b0;
        wait_bk(1'b0);
        apb(1'b0, 8'h0c, 8'h02);
        apb(1'b1, 8'h0c, 8'h00);
        apb(1'b0, 8'h0c, 8'h00);
        $display("monitor and forced break done");
        apb(1'b1, 8'h00, 8'h00);
        apb(1'b1, 8'h08, lo);
        repeat (40) @(posedge mclk);
        chk("disabled", 16'h0, {15'h0, breakpoint_request});
        $display("disabled break done");
        final_report();
    end
endmodule // abu_top_tb

bind abu_top abu_assertions chk_i (
    .mclk(mclk),
    .nrst(nrst),
    .psel(psel),
    .penable(penable),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .cpu_rti_done(cpu_rti_done),
    .monitor_mode(monitor_mode),
    .breakpoint_request(breakpoint_request),
    .break_vector(break_vector),
    .break_state(break_state),
    .timer_hold(timer_hold),
    .watchdog_disable(watchdog_disable)
);
